// File: src/amts_top.v
// motor-synchronous converter sequencer with avalon register slave
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`include "amts_defs.vh"

// Summary of operation
// R01: software polls done flag until set
// R02: result stored before done flag rises
// R03: host reads result only after done
// R04: host reads result as one access
// R05: overwrite 0, valid 1 means fresh result
// R06: sync select 1 starts on motor triggers
// R07: three motor trigger sources, numbered 0-2
// R08: eight result registers in this unit
// R09: channel and trigger per result register
// R10: per-register enable, disabled ones skipped
// R11: counter: every cycle or after N
// R12: interrupt when enabled programme completes
// R13: two-bit select per result, 11 reserved
// R14: software clears done flag writing 0
// R15: reserved select code means no trigger
// R16: trigger-select bytes reset to zero
module amts_top #(
  parameter DATA_W = 10,
  parameter CNT_W = 8
) (
  input wire CLK_SYS,
  input wire RST,
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  input wire [2:0] MOTOR_TRIG,
  output reg CONV_START,
  output reg [2:0] CONV_CHANNEL,
  input wire CONV_DONE,
  input wire [DATA_W-1:0] CONV_RESULT,
  output reg CONV_IRQ,
  output wire SEQ_BUSY
);

  // sequencer states
  localparam S_IDLE = 2'h0;
  localparam S_START = 2'h1;
  localparam S_WAIT = 2'h2;

  // merge one byte lane of write data into an 8-bit field
  function [7:0] lane_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input en;
    begin
      lane_merge = en ? new_v : old_v;
    end
  endfunction

  // lowest set bit of a pending mask
  function [2:0] pick_low;
    input [7:0] mask;
    integer k;
    begin
      pick_low = 3'h0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (mask[k]) begin
          pick_low = k[2:0];
        end
      end
    end
  endfunction

  // software-visible state
  reg [7:0] trig_lo_q; // selects for results 0..3
  reg [7:0] trig_hi_q; // selects for results 4..7
  reg done_flag_q; // conversion_done_flag
  reg sync_sel_q; // motor_sync_select
  reg cnt_mode_q; // 0: every cycle, 1: after count
  reg [7:0] en_q; // per-result enable
  reg [23:0] chan_q; // per-result input channel
  reg [CNT_W-1:0] cnt_target_q; // programmed cycle count
  reg [CNT_W-1:0] cnt_q; // completed cycles so far
  reg [7:0] valid_q; // result_valid_flag per result
  reg [7:0] ovr_q; // overwrite_flag per result

  // sequencer state
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] pend_q; // triggered, not yet converted
  reg [7:0] pend_d;
  reg [7:0] doneset_q; // converted in this programme cycle
  reg [7:0] doneset_d;
  reg [2:0] cur_q; // result register being converted
  reg [7:0] hit; // results whose trigger fired now
  reg [1:0] sel; // loop temporary
  integer i;

  // bus handshake state
  reg [1:0] rd_stage_q;
  wire [15:0] trig_all = {trig_hi_q, trig_lo_q};
  wire [DATA_W-1:0] mem_rdata;
  wire res_addr = AVS_ADDRESS[`AMTS_RES_BASE_BIT];
  wire [2:0] res_idx = AVS_ADDRESS[2:0];
  wire wr_mode = AVS_WRITE && (AVS_ADDRESS == `AMTS_IDX_MODE);

  // conversion completion and programme completion
  wire conv_end = (state_q == S_WAIT) && CONV_DONE;
  wire [7:0] doneset_nx = doneset_q | (8'h01 << cur_q); // built off doneset_q, no comb loop
  wire prog_end = conv_end && (en_q != 8'h00) && ((doneset_nx & en_q) == en_q); // R12
  wire cnt_hit = cnt_mode_q && ((cnt_q + 1'b1) >= cnt_target_q); // R11
  wire irq_now = prog_end && (!cnt_mode_q || cnt_hit); // R11
  wire rd_clear = (rd_stage_q == `AMTS_RD_ACK) && AVS_READ && res_addr;

  // writes finish at once; reads wait for the registered fetch
  assign AVS_WAITREQUEST = !(AVS_WRITE || (AVS_READ && (rd_stage_q == `AMTS_RD_ACK)));
  assign SEQ_BUSY = (state_q != S_IDLE) || (pend_q != 8'h00);

  // result storage, written on each finished conversion
  amts_result_mem #(
    .DATA_W(DATA_W),
    .ADDR_W(`AMTS_IDX_W)
  ) u_mem (
    .clk(CLK_SYS),
    .rst(RST),
    .wr_en(conv_end), // R02
    .wr_addr(cur_q), // R08
    .wr_data(CONV_RESULT),
    .rd_addr(res_idx),
    .rd_data(mem_rdata)
  );

  // match each result's trigger select against the live triggers
  always @* begin
    hit = 8'h00;
    sel = 2'h0;
    for (i = 0; i < `AMTS_NRES; i = i + 1) begin
      sel = trig_all[2*i +: 2]; // R13
      // reserved code never fires, whatever the triggers do
      if (sel != `AMTS_TRG_NONE) begin // R15
        if (MOTOR_TRIG[sel]) begin // R07
          hit[i] = 1'b1; // R09
        end
      end
    end
  end

  // sequencer next state
  always @* begin
    state_d = state_q;
    pend_d = pend_q;
    doneset_d = doneset_q;
    case (state_q)
      S_IDLE: begin
        // disabled entries are dropped rather than converted
        if ((pend_q & en_q) != 8'h00) begin // R10
          state_d = S_START;
        end
      end
      S_START: begin
        // selected entry leaves the pending set
        pend_d[cur_q] = 1'b0;
        state_d = S_WAIT;
      end
      S_WAIT: begin
        if (CONV_DONE) begin
          doneset_d[cur_q] = 1'b1;
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    // a completed programme or new enables start a fresh round, so stale entries never count
    if (prog_end || (AVS_WRITE && (AVS_ADDRESS == `AMTS_IDX_ENABLE))) begin // R12
      doneset_d = 8'h00;
    end
    // new triggers only count in motor-synchronous mode
    if (sync_sel_q) begin // R06
      pend_d = (pend_d & en_q) | (hit & en_q); // R10
    end else begin
      pend_d = 8'h00;
    end
  end

  // sequencer registers and converter drive
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_q <= S_IDLE;
      pend_q <= 8'h00;
      doneset_q <= 8'h00;
      cur_q <= 3'h0;
      CONV_START <= 1'b0;
      CONV_CHANNEL <= 3'h0;
      CONV_IRQ <= 1'b0;
      cnt_q <= {CNT_W{1'b0}};
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
      doneset_q <= doneset_d;
      CONV_START <= 1'b0;
      CONV_IRQ <= irq_now; // R12
      // lock in the entry and its own channel on the same edge as the start pulse
      if ((state_q == S_IDLE) && (state_d == S_START)) begin
        cur_q <= pick_low(pend_q & en_q);
        CONV_CHANNEL <= chan_q[3*pick_low(pend_q & en_q) +: 3]; // R09
        CONV_START <= 1'b1; // R06
      end
      // cycle counter: restart on reaching target or in every-cycle mode, else advance
      if (prog_end) begin
        if (!cnt_mode_q || cnt_hit) begin // R11
          cnt_q <= {CNT_W{1'b0}};
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  // per-result valid and overwrite flags
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      valid_q <= 8'h00;
      ovr_q <= 8'h00;
    end else begin
      // a read of the result clears both flags
      if (rd_clear) begin
        valid_q[res_idx] <= 1'b0;
        ovr_q[res_idx] <= 1'b0;
      end
      // a new result wins over a read clear in the same cycle
      if (conv_end) begin
        valid_q[cur_q] <= 1'b1; // R05
        ovr_q[cur_q] <= valid_q[cur_q] && !(rd_clear && (res_idx == cur_q)); // R05
      end
    end
  end

  // done flag: set by hardware, cleared by writing zero
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      done_flag_q <= 1'b0;
    end else begin
      if (irq_now) begin
        // memory write lands on this same edge, so the result is ready
        done_flag_q <= 1'b1; // R02
      end else if (wr_mode && AVS_BYTEENABLE[0] && !AVS_WRITEDATA[`AMTS_MODE_DONE_BIT]) begin
        done_flag_q <= 1'b0; // R14
      end
    end
  end

  // software-written control registers
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      trig_lo_q <= `AMTS_RST_TRIG; // R16
      trig_hi_q <= `AMTS_RST_TRIG; // R16
      sync_sel_q <= 1'b0;
      cnt_mode_q <= 1'b0;
      en_q <= `AMTS_RST_ENABLE;
      chan_q <= `AMTS_RST_CHAN;
      cnt_target_q <= `AMTS_RST_COUNT;
    end else if (AVS_WRITE) begin
      case (AVS_ADDRESS)
        `AMTS_IDX_TRIG_LO: begin
          trig_lo_q <= lane_merge(trig_lo_q, AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0]); // R13
        end
        `AMTS_IDX_TRIG_HI: begin
          trig_hi_q <= lane_merge(trig_hi_q, AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0]); // R13
        end
        `AMTS_IDX_MODE: begin
          if (AVS_BYTEENABLE[0]) begin
            sync_sel_q <= AVS_WRITEDATA[`AMTS_MODE_SYNC_BIT]; // R06
            cnt_mode_q <= AVS_WRITEDATA[`AMTS_MODE_CNT_BIT]; // R11
          end
        end
        `AMTS_IDX_ENABLE: begin
          en_q <= lane_merge(en_q, AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0]); // R10
        end
        `AMTS_IDX_CHAN: begin
          chan_q[7:0] <= lane_merge(chan_q[7:0], AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0]);
          chan_q[15:8] <= lane_merge(chan_q[15:8], AVS_WRITEDATA[15:8], AVS_BYTEENABLE[1]);
          chan_q[23:16] <= lane_merge(chan_q[23:16], AVS_WRITEDATA[23:16], AVS_BYTEENABLE[2]);
        end
        `AMTS_IDX_COUNT: begin
          cnt_target_q <= lane_merge(cnt_target_q, AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0]);
        end
        default: begin
          // unmapped or read-only index: write ignored
        end
      endcase
    end
  end

  // read path: fetch stage lets the memory register its word
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rd_stage_q <= `AMTS_RD_IDLE;
      AVS_READDATA <= 32'h00000000;
    end else begin
      case (rd_stage_q)
        `AMTS_RD_IDLE: begin
          if (AVS_READ) begin
            rd_stage_q <= `AMTS_RD_FETCH;
          end
        end
        `AMTS_RD_FETCH: begin
          rd_stage_q <= `AMTS_RD_ACK;
          AVS_READDATA <= 32'h00000000;
          if (res_addr) begin
            // data and both flags in one word so they cannot tear
            AVS_READDATA[DATA_W-1:0] <= mem_rdata; // R04
            AVS_READDATA[`AMTS_RES_OVR_BIT] <= ovr_q[res_idx]; // R05
            AVS_READDATA[`AMTS_RES_VAL_BIT] <= valid_q[res_idx]; // R05
          end else begin
            case (AVS_ADDRESS)
              `AMTS_IDX_TRIG_LO: AVS_READDATA[7:0] <= trig_lo_q;
              `AMTS_IDX_TRIG_HI: AVS_READDATA[7:0] <= trig_hi_q;
              `AMTS_IDX_MODE: begin
                AVS_READDATA[`AMTS_MODE_DONE_BIT] <= done_flag_q; // R01
                AVS_READDATA[`AMTS_MODE_SYNC_BIT] <= sync_sel_q;
                AVS_READDATA[`AMTS_MODE_CNT_BIT] <= cnt_mode_q;
                AVS_READDATA[15:8] <= cnt_q;
              end
              `AMTS_IDX_ENABLE: AVS_READDATA[7:0] <= en_q;
              `AMTS_IDX_CHAN: AVS_READDATA[23:0] <= chan_q;
              `AMTS_IDX_COUNT: AVS_READDATA[7:0] <= cnt_target_q;
              default: AVS_READDATA <= 32'h00000000;
            endcase
          end
        end
        default: begin
          // ack stage: master samples the answer at this edge and drops read
          rd_stage_q <= `AMTS_RD_IDLE;
        end
      endcase
    end
  end

endmodule

// File: inc/amts_defs.vh
// register map, field layout, reset values and sequencer codes of the trigger sequencer
`ifndef AMTS_DEFS_VH
`define AMTS_DEFS_VH

// printed register locations of the trigger-select bytes, kept for reference
`define AMTS_PRINTED_TRIG_LO 32'hFFFFCD40
`define AMTS_PRINTED_TRIG_HI 32'hFFFFCD41

// word indices on the avalon slave (byte address is four times the index)
`define AMTS_IDX_TRIG_LO 4'h0
`define AMTS_IDX_TRIG_HI 4'h1
`define AMTS_IDX_MODE 4'h2
`define AMTS_IDX_ENABLE 4'h3
`define AMTS_IDX_CHAN 4'h4
`define AMTS_IDX_COUNT 4'h5
// indices 8 to 15 hold the eight result registers
`define AMTS_RES_BASE_BIT 3

// geometry
`define AMTS_NRES 8
`define AMTS_SEL_W 2
`define AMTS_CHAN_W 3
`define AMTS_IDX_W 3

// mode register fields
`define AMTS_MODE_DONE_BIT 0
`define AMTS_MODE_SYNC_BIT 1
`define AMTS_MODE_CNT_BIT 2

// result register fields
`define AMTS_RES_OVR_BIT 14
`define AMTS_RES_VAL_BIT 15

// trigger-select codes
`define AMTS_TRG_0 2'h0
`define AMTS_TRG_1 2'h1
`define AMTS_TRG_2 2'h2
`define AMTS_TRG_NONE 2'h3

// reset values
`define AMTS_RST_TRIG 8'h00
`define AMTS_RST_ENABLE 8'h00
`define AMTS_RST_CHAN 24'h000000
`define AMTS_RST_COUNT 8'h00

// read handshake stages
`define AMTS_RD_IDLE 2'h0
`define AMTS_RD_FETCH 2'h1
`define AMTS_RD_ACK 2'h2

`endif

// File: src/amts_result_mem.v
// small result memory with registered read data
`timescale 1ns/1ps
module amts_result_mem #(
  parameter DATA_W = 10,
  parameter ADDR_W = 3
) (
  input wire clk,
  input wire rst,
  input wire wr_en,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [DATA_W-1:0] wr_data,
  input wire [ADDR_W-1:0] rd_addr,
  output reg [DATA_W-1:0] rd_data
);

  // storage array, no reset needed since valid flags live outside
  reg [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];

  // write port
  always @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // read port, old data on a same-address collision
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= {DATA_W{1'b0}};
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule

// File: dv/amts_top_props.sv
// port-level assertions for the trigger sequencer
`timescale 1ns/1ps
module amts_top_props (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic CONV_START,
  input wire logic [2:0] CONV_CHANNEL,
  input wire logic CONV_DONE,
  input wire logic CONV_IRQ,
  input wire logic SEQ_BUSY
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // a read waits exactly two cycles, then is answered
  sequence rd_ack_s;
    AVS_WAITREQUEST [*2] ##1 !AVS_WAITREQUEST;
  endsequence
  read_wait_a: assert property ($rose(AVS_READ) |-> rd_ack_s)
    else $error("read not answered after two waits");
  write_nowait_a: assert property (AVS_WRITE |-> !AVS_WAITREQUEST)
    else $error("write stalled");
  start_pulse_a: assert property (CONV_START |=> !CONV_START)
    else $error("start longer than one cycle");
  start_cause_a: assert property (CONV_START |-> $past(SEQ_BUSY))
    else $error("start without pending work");
  chan_stable_a: assert property (!CONV_START |-> $stable(CONV_CHANNEL))
    else $error("channel moved between starts");
  done_gap_a: assert property (CONV_DONE |=> !CONV_START)
    else $error("start directly after done");
  irq_pulse_a: assert property (CONV_IRQ |=> !CONV_IRQ)
    else $error("interrupt longer than one cycle");
  irq_cause_a: assert property (CONV_IRQ |-> $past(CONV_DONE))
    else $error("interrupt without a finished conversion");
endmodule
bind amts_top amts_top_props u_props (.CLK_SYS(CLK_SYS), .RST(RST), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .CONV_START(CONV_START),
  .CONV_CHANNEL(CONV_CHANNEL), .CONV_DONE(CONV_DONE), .CONV_IRQ(CONV_IRQ),
  .SEQ_BUSY(SEQ_BUSY));

// File: dv/amts_conv_model.sv
// converter model: answers each start with one done pulse
`timescale 1ns/1ps
module amts_conv_model (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [2:0] ch,
  input wire slow,
  output reg done,
  output reg [9:0] result
);
  reg [2:0] cnt_q; // cycles left before answering
  reg busy_q; // conversion in flight
  // result toggles outside done so stale data never looks valid
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q <= 3'h0;
      done <= 1'b0;
      result <= 10'h3FF;
    end else begin
      done <= 1'b0;
      result <= ~result;
      if (start) begin
        busy_q <= 1'b1;
        cnt_q <= slow ? 3'h6 : 3'h1;
      end else if (busy_q && cnt_q == 3'h0) begin
        busy_q <= 1'b0;
        done <= 1'b1;
        result <= {ch, 7'h55};
      end else if (busy_q) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule

// File: dv/amts_top_tb.sv
// self-checking bench of the trigger sequencer
`timescale 1ns/1ps
module amts_top_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] adr = 4'h0;
  reg rd_s = 1'b0;
  reg wr_s = 1'b0;
  reg [31:0] wdat = 32'h0;
  reg [2:0] trig = 3'h0;
  reg slow = 1'b0;
  wire [31:0] rdat;
  wire wait_s;
  wire start;
  wire [2:0] chan;
  wire done;
  wire [9:0] res;
  wire irq;
  wire busy;
  integer fails = 0;
  integer tests_run = 0;
  integer seed = 32'h5be3cfbe;
  integer irqs = 0;
  integer i, k, n, r, d;
  reg [31:0] v;
  reg [15:0] sel;
  reg [23:0] chs;
  reg [7:0] en;
  reg all;
  reg [2:0] q[$]; // channels seen at each start
  amts_top uut (.CLK_SYS(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_s),
    .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wait_s), .MOTOR_TRIG(trig), .CONV_START(start), .CONV_CHANNEL(chan),
    .CONV_DONE(done), .CONV_RESULT(res), .CONV_IRQ(irq), .SEQ_BUSY(busy));
  amts_conv_model u_conv (.clk(clk), .rst(rst), .start(start), .ch(chan), .slow(slow),
    .done(done), .result(res));
  initial forever #25 clk = ~clk;
  // monitor starts and interrupts
  always @(posedge clk) begin
    if (start === 1'b1) q.push_back(chan);
    if (irq === 1'b1) irqs = irqs + 1;
  end
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task tmo(input integer c);
    if (c >= 300) begin
      fails = fails + 1;
      $display("[ERR] %0t wait ran out", $time);
      end_of_test;
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task bus(input w, input [3:0] a, input [31:0] dt);
    integer c;
    begin
      @(posedge clk);
      adr <= a;
      wdat <= dt;
      wr_s <= w;
      rd_s <= !w;
      c = 0;
      do begin
        @(posedge clk);
        c = c + 1;
      end while (wait_s !== 1'b0 && c < 300);
      tmo(c);
      v = rdat;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
    end
  endtask
  // one-cycle trigger event, then wait for the sequencer to settle
  task pulse(input integer t);
    integer c;
    begin
      @(posedge clk);
      trig <= 3'h1 << t;
      slow <= $random(seed);
      @(posedge clk);
      trig <= 3'h0;
      repeat (3) @(posedge clk);
      c = 0;
      while (busy !== 1'b0 && c < 300) begin
        @(posedge clk);
        c = c + 1;
      end
      tmo(c);
      repeat (2) @(posedge clk);
    end
  endtask
  function [31:0] rword(input [2:0] c, input o);
    rword = {16'h0, 1'b1, o, 4'h0, c, 7'h55};
  endfunction
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      bus(1'b0, i, 32'h0);
      chk(v, 32'h0);
    end
    bus(1'b1, 4'h6, 32'hFFFFFFFF);
    bus(1'b0, 4'h6, 32'h0);
    chk(v, 32'h0);
    // random programmes, first one every result on a real trigger
    for (r = 0; r < 4; r = r + 1) begin
      sel = $random(seed);
      chs = $random(seed);
      en = $random(seed);
      if (r == 0) begin
        en = 8'hFF;
        for (n = 0; n < 8; n = n + 1) sel[2*n+:2] = n % 3;
      end
      bus(1'b1, 4'h0, sel[7:0]);
      bus(1'b1, 4'h1, sel[15:8]);
      bus(1'b1, 4'h3, en);
      bus(1'b1, 4'h4, chs);
      bus(1'b1, 4'h2, 32'h2);
      bus(1'b0, 4'h1, 32'h0);
      chk(v, sel[15:8]);
      d = irqs;
      all = (en != 8'h0);
      for (k = 0; k < 3; k = k + 1) begin
        pulse(k);
        for (n = 0; n < 8; n = n + 1)
          if (en[n] && sel[2*n+:2] == k) chk(q.pop_front(), chs[3*n+:3]);
        chk(q.size(), 0);
      end
      for (n = 0; n < 8; n = n + 1) if (en[n] && sel[2*n+:2] == 2'h3) all = 1'b0;
      chk(irqs - d, all);
      if (all) begin
        bus(1'b0, 4'h2, 32'h0);
        chk(v[0], 1'b1);
        bus(1'b1, 4'h2, 32'h2);
        bus(1'b0, 4'h2, 32'h0);
        chk(v[0], 1'b0);
      end
      for (n = 0; n < 8; n = n + 1) begin
        bus(1'b0, 8 + n, 32'h0);
        if (en[n] && sel[2*n+:2] != 2'h3) chk(v, rword(chs[3*n+:3], 1'b0));
        else chk(v[15:14], 2'h0);
      end
    end
    // second conversion before the read marks the overwrite
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h1, 32'h0);
    bus(1'b1, 4'h3, 32'h1);
    bus(1'b1, 4'h4, 32'h5);
    pulse(0);
    pulse(0);
    bus(1'b0, 4'h8, 32'h0);
    chk(v, rword(3'h5, 1'b1));
    bus(1'b0, 4'h8, 32'h0);
    chk(v[15:14], 2'h0);
    // counted mode: two programme cycles per interrupt
    bus(1'b1, 4'h5, 32'h2);
    bus(1'b1, 4'h2, 32'h6);
    d = irqs;
    pulse(0);
    pulse(0);
    chk(irqs - d, 1);
    // sync off: triggers are ignored
    bus(1'b1, 4'h2, 32'h0);
    q.delete();
    d = irqs;
    pulse(0);
    chk(q.size(), 0);
    chk(irqs - d, 0);
    end_of_test;
  end
endmodule
